/* File: shared/touch_key_regs.svh */
`ifndef TOUCH_KEY_REGS_SVH
`define TOUCH_KEY_REGS_SVH

// register indices on the plain register port
`define TK_ADDR_CTRL 4'h0
`define TK_ADDR_START 4'h1
`define TK_ADDR_SLOT_PRESET 4'h2
`define TK_ADDR_STATUS 4'h3
`define TK_ADDR_MASK 4'h4
`define TK_ADDR_CF_LO 4'h5
`define TK_ADDR_CF_HI 4'h6
`define TK_ADDR_FN_LO 4'h7
`define TK_ADDR_FN_HI 4'h8

// touch_module_control_one fields
`define TK_CTRL_SLOT_SEL 7
`define TK_CTRL_REF_EN 5
`define TK_CTRL_KEY_OSC_EN 4
`define TK_CTRL_K2_EN 1
`define TK_CTRL_K1_EN 0
`define TK_CTRL_WMASK 8'hB3
`define TK_CTRL_RESET 8'h00

// start register and status / mask layout
`define TK_START_BIT 0
`define TK_STAT_SLOT_OV 0
`define TK_STAT_CF_OV 1
`define TK_STAT_FN_OV 2
`define TK_STAT_WIDTH 3
`define TK_STAT_RESET 3'h0
`define TK_SLOT_PRESET_RESET 8'h00

// counter terminal values
`define TK_SYS_DIV_LAST 2'h3
`define TK_UNIT_LAST 5'h1F
`define TK_SLOT_LAST 8'hFF

`endif

/* File: shared/touch_key_pkg.sv */
package touch_key_pkg;

  // gray sequence idle -> run -> done
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN = 2'b01,
    ST_DONE = 2'b11
  } window_state_e;

  typedef logic [15:0] count16_t;

endpackage : touch_key_pkg

/* File: rtl/touch_key_cf_measurement.sv */
// Notes on behaviour
// - slot clock: reference osc, or system/4
// - oscillators run only while enabled
// - each key measured only when enabled
// - control bits 6,3,2 read zero
// - count sense cycles over fixed window
// - one sense oscillator per key
// - start low zeroes counters, keeps slot
// - start rising switches all counters on
// - start rising enables, synchronises oscillators
// - slot overflow stops oscillators and counters
// - slot overflow raises the touch interrupt
// - interrupt clears all four counters
// - software presets slot overflow time first
// - sticky slot overflow flag, software clears
// - sticky frequency counter overflow flag
// - sticky function counter overflow flag
//
// The implementer's own choices: the placing of the registers and strobed register access.
`timescale 1ns/10ps
`include "touch_key_regs.svh"

module touch_key_cf_measurement
  import touch_key_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  output logic o_irq,
  input wire logic i_ref_osc,
  input wire logic i_first_key_input,
  input wire logic i_second_key_input,
  output logic o_ref_osc_en,
  output logic [1:0] o_key_osc_en,
  output logic o_osc_sync,
  output logic o_window_active
);

  ////////////////////////////////////////////////////////////////////////////
  // state

  window_state_e state_q, state_d;
  logic [7:0] ctrl_q, ctrl_d;
  logic start_q, start_d;
  logic start_prev_q, start_prev_d;
  logic [7:0] slot_preset_q, slot_preset_d;
  logic [`TK_STAT_WIDTH-1:0] stat_q, stat_d;
  logic [`TK_STAT_WIDTH-1:0] mask_q, mask_d;
  logic [1:0] sys_div_q, sys_div_d;
  logic [4:0] unit_q, unit_d;
  logic [7:0] slot_q, slot_d;
  count16_t cf_q, cf_d;
  count16_t fn_q, fn_d;
  count16_t cf_result_q, cf_result_d;
  count16_t fn_result_q, fn_result_d;
  logic ref_prev_q, ref_prev_d;
  logic [1:0] key_prev_q, key_prev_d;
  logic [7:0] rdata_q, rdata_d;
  logic irq_q, irq_d;
  logic ref_en_q, ref_en_d;
  logic [1:0] key_en_q, key_en_d;
  logic sync_q, sync_d;
  // window flag gets its own flop so the pin is not a gate after the registers
  logic active_q, active_d;

  // events of the current cycle
  logic start_rise;
  logic sys_tick;
  logic ref_edge;
  logic slot_tick;
  logic unit_wrap;
  logic slot_ovf;
  logic [1:0] key_edge;
  logic [16:0] cf_sum;
  logic [16:0] fn_sum;
  logic cf_carry;
  logic fn_carry;
  logic running;
  logic [`TK_STAT_WIDTH-1:0] stat_clr;

  ////////////////////////////////////////////////////////////////////////////
  // next-state logic

  always_comb begin
    state_d = state_q;
    ctrl_d = ctrl_q;
    start_d = start_q;
    start_prev_d = start_q;
    slot_preset_d = slot_preset_q;
    mask_d = mask_q;
    sys_div_d = sys_div_q + 2'h1;
    unit_d = unit_q;
    slot_d = slot_q;
    cf_d = cf_q;
    fn_d = fn_q;
    cf_result_d = cf_result_q;
    fn_result_d = fn_result_q;
    ref_prev_d = i_ref_osc;
    key_prev_d = {i_second_key_input, i_first_key_input};
    rdata_d = 8'h00;
    stat_clr = '0;

    running = (state_q == ST_RUN) && start_q;
    start_rise = start_q && !start_prev_q && (state_q == ST_IDLE);
    sys_tick = (sys_div_q == `TK_SYS_DIV_LAST);
    // oscillator is stopped outside the window, so its pin is only trusted while running
    ref_edge = i_ref_osc && !ref_prev_q && ref_en_q;
    slot_tick = running && (ctrl_q[`TK_CTRL_SLOT_SEL] ? sys_tick : ref_edge);
    unit_wrap = slot_tick && (unit_q == `TK_UNIT_LAST);
    slot_ovf = unit_wrap && (slot_q == `TK_SLOT_LAST);

    // one sense oscillator per key, each gated by its own enable
    key_edge[0] = i_first_key_input && !key_prev_q[0] && key_en_q[0];
    key_edge[1] = i_second_key_input && !key_prev_q[1] && key_en_q[1];
    // both keys may edge in the same cycle, and each edge adds exactly one
    cf_sum = {1'b0, cf_q} + {16'h0000, key_edge[0]}
             + {16'h0000, key_edge[1]};
    fn_sum = {1'b0, fn_q} + {16'h0000, sys_tick};
    cf_carry = running && cf_sum[16];
    fn_carry = running && fn_sum[16];

    // register writes
    if (i_wr) begin
      unique case (i_addr)
        `TK_ADDR_CTRL: ctrl_d = i_wdata & `TK_CTRL_WMASK;
        `TK_ADDR_START: start_d = i_wdata[`TK_START_BIT];
        `TK_ADDR_SLOT_PRESET: slot_preset_d = i_wdata;
        `TK_ADDR_STATUS: stat_clr = i_wdata[`TK_STAT_WIDTH-1:0];
        `TK_ADDR_MASK: mask_d = i_wdata[`TK_STAT_WIDTH-1:0];
        default: ;
      endcase
    end

    // window sequencing
    unique case (state_q)
      ST_IDLE: begin
        if (start_rise) begin
          state_d = ST_RUN;
          slot_d = slot_preset_d;
          cf_result_d = 16'h0000;
          fn_result_d = 16'h0000;
        end
      end
      ST_RUN: begin
        if (!start_q) begin
          state_d = ST_IDLE;
        end else if (slot_ovf) begin
          state_d = ST_DONE;
        end
      end
      ST_DONE: begin
        if (!start_q) begin
          state_d = ST_IDLE;
        end
      end
      default: state_d = ST_IDLE;
    endcase

    if (running) begin
      if (slot_tick) begin
        unit_d = unit_q + 5'h01;
      end
      if (unit_wrap) begin
        slot_d = slot_q + 8'h01;
      end
      cf_d = cf_sum[15:0];
      fn_d = fn_sum[15:0];
    end

    if (slot_ovf) begin
      // latch the count before clearing so software can still judge the touch
      cf_result_d = cf_sum[15:0];
      fn_result_d = fn_sum[15:0];
      cf_d = 16'h0000;
      fn_d = 16'h0000;
      unit_d = 5'h00;
      slot_d = 8'h00;
    end

    if (!start_q) begin
      // slot counter is left alone here
      cf_d = 16'h0000;
      fn_d = 16'h0000;
      unit_d = 5'h00;
    end

    // sticky flags: a set in the clearing cycle wins
    stat_d = stat_q & ~stat_clr;
    stat_d[`TK_STAT_SLOT_OV] = stat_d[`TK_STAT_SLOT_OV] | slot_ovf;
    stat_d[`TK_STAT_CF_OV] = stat_d[`TK_STAT_CF_OV] | cf_carry;
    stat_d[`TK_STAT_FN_OV] = stat_d[`TK_STAT_FN_OV] | fn_carry;
    irq_d = |(stat_d & mask_d);

    // oscillators follow their enables and stop at overflow
    ref_en_d = ctrl_d[`TK_CTRL_REF_EN] && (state_d == ST_RUN);
    key_en_d[0] = ctrl_d[`TK_CTRL_KEY_OSC_EN] && ctrl_d[`TK_CTRL_K1_EN]
                  && (state_d == ST_RUN);
    key_en_d[1] = ctrl_d[`TK_CTRL_KEY_OSC_EN] && ctrl_d[`TK_CTRL_K2_EN]
                  && (state_d == ST_RUN);
    sync_d = start_rise;
    active_d = (state_d == ST_RUN);

    // register reads
    if (i_rd) begin
      unique case (i_addr)
        `TK_ADDR_CTRL: rdata_d = ctrl_q & `TK_CTRL_WMASK;
        `TK_ADDR_START: rdata_d = {7'h00, start_q};
        `TK_ADDR_SLOT_PRESET: rdata_d = slot_preset_q;
        `TK_ADDR_STATUS: rdata_d = {5'h00, stat_q};
        `TK_ADDR_MASK: rdata_d = {5'h00, mask_q};
        `TK_ADDR_CF_LO: rdata_d = cf_result_q[7:0];
        `TK_ADDR_CF_HI: rdata_d = cf_result_q[15:8];
        `TK_ADDR_FN_LO: rdata_d = fn_result_q[7:0];
        `TK_ADDR_FN_HI: rdata_d = fn_result_q[15:8];
        default: rdata_d = 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      state_q <= ST_IDLE;
      ctrl_q <= `TK_CTRL_RESET;
      start_q <= 1'b0;
      start_prev_q <= 1'b0;
      slot_preset_q <= `TK_SLOT_PRESET_RESET;
      stat_q <= `TK_STAT_RESET;
      mask_q <= `TK_STAT_RESET;
      sys_div_q <= 2'h0;
      unit_q <= 5'h00;
      slot_q <= 8'h00;
      cf_q <= 16'h0000;
      fn_q <= 16'h0000;
      cf_result_q <= 16'h0000;
      fn_result_q <= 16'h0000;
      ref_prev_q <= 1'b0;
      key_prev_q <= 2'h0;
      rdata_q <= 8'h00;
      irq_q <= 1'b0;
      ref_en_q <= 1'b0;
      key_en_q <= 2'h0;
      sync_q <= 1'b0;
      active_q <= 1'b0;
    end else begin
      state_q <= state_d;
      ctrl_q <= ctrl_d;
      start_q <= start_d;
      start_prev_q <= start_prev_d;
      slot_preset_q <= slot_preset_d;
      stat_q <= stat_d;
      mask_q <= mask_d;
      sys_div_q <= sys_div_d;
      unit_q <= unit_d;
      slot_q <= slot_d;
      cf_q <= cf_d;
      fn_q <= fn_d;
      cf_result_q <= cf_result_d;
      fn_result_q <= fn_result_d;
      ref_prev_q <= ref_prev_d;
      key_prev_q <= key_prev_d;
      rdata_q <= rdata_d;
      irq_q <= irq_d;
      ref_en_q <= ref_en_d;
      key_en_q <= key_en_d;
      sync_q <= sync_d;
      active_q <= active_d;
    end
  end

  assign o_rdata = rdata_q;
  assign o_irq = irq_q;
  assign o_ref_osc_en = ref_en_q;
  assign o_key_osc_en = key_en_q;
  assign o_osc_sync = sync_q;
  assign o_window_active = active_q;

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rst_n);

  a_slot_source:
    assert property (ctrl_q[`TK_CTRL_SLOT_SEL] && !sys_tick |-> !slot_tick)
    else $error("slot tick taken from reference while system/4 selected");

  a_ref_osc_gate:
    assert property (!ctrl_q[`TK_CTRL_REF_EN] && !i_wr |=> !o_ref_osc_en)
    else $error("reference oscillator runs while disabled");

  a_key_gate:
    assert property ((!ctrl_q[`TK_CTRL_K1_EN] || !ctrl_q[`TK_CTRL_KEY_OSC_EN]) && !i_wr
                     |=> !o_key_osc_en[0])
    else $error("first key oscillator runs while disabled");

  a_unused_zero:
    assert property (i_rd && i_addr == `TK_ADDR_CTRL
                     |=> o_rdata[6] == 1'b0 && o_rdata[3:2] == 2'h0)
    else $error("unused control bits read nonzero");

  a_stop_clears:
    assert property (!start_q |=> unit_q == 5'h00 && cf_q == 16'h0000 && fn_q == 16'h0000)
    else $error("counters not zero while start is low");

  a_slot_held:
    assert property (state_q == ST_IDLE && !start_q |=> slot_q == $past(slot_q))
    else $error("slot counter changed while start is low");

  a_rise_runs:
    assert property (start_rise |=> state_q == ST_RUN && slot_q == $past(slot_preset_q))
    else $error("start edge did not open the window with the preset");

  a_rise_sync:
    assert property (start_rise |=> o_osc_sync ##1 !o_osc_sync)
    else $error("oscillator sync pulse wrong");

  a_ovf_stops:
    assert property (slot_ovf |=> state_q == ST_DONE && !o_ref_osc_en && o_key_osc_en == 2'h0)
    else $error("oscillators still enabled after slot overflow");

  a_ovf_irq:
    assert property (slot_ovf && mask_q[`TK_STAT_SLOT_OV] && !i_wr |=> o_irq)
    else $error("no interrupt on slot overflow");

  a_ovf_clears:
    assert property (slot_ovf |=> cf_q == 16'h0000 && fn_q == 16'h0000
                     && unit_q == 5'h00 && slot_q == 8'h00)
    else $error("counters not cleared at interrupt");

  a_slot_flag_sticky:
    assert property (stat_q[`TK_STAT_SLOT_OV]
                     && !(i_wr && i_addr == `TK_ADDR_STATUS && i_wdata[`TK_STAT_SLOT_OV])
                     |=> stat_q[`TK_STAT_SLOT_OV])
    else $error("slot overflow flag cleared by hardware");

  a_cf_flag_set:
    assert property (cf_carry |=> stat_q[`TK_STAT_CF_OV])
    else $error("frequency overflow flag not set");

  a_fn_flag_set:
    assert property (fn_carry |=> stat_q[`TK_STAT_FN_OV])
    else $error("function overflow flag not set");

  a_result_kept:
    assert property (state_q == ST_DONE && start_q |=> $stable(cf_result_q))
    else $error("captured count lost after window");

  // two keys edging together must not be counted as a weighted pair
  a_pair_count:
    assert property (running && !slot_ovf && key_edge == 2'h3
                     |=> cf_q == $past(cf_q) + 16'h0002)
    else $error("simultaneous key edges miscounted");

  a_results_zero:
    assert property (start_rise |=> cf_result_q == 16'h0000 && fn_result_q == 16'h0000)
    else $error("results not zeroed at window start");

  a_active_flag:
    assert property (o_window_active == (state_q == ST_RUN))
    else $error("window flag disagrees with window state");

  c_window_done: cover property (state_q == ST_RUN ##1 state_q == ST_DONE);
  c_window_abort: cover property (state_q == ST_RUN && !start_q);
  c_both_keys: cover property (key_edge == 2'h3);
  c_cf_overflow: cover property (cf_carry);
  c_sys_window: cover property (ctrl_q[`TK_CTRL_SLOT_SEL] && slot_ovf);

endmodule : touch_key_cf_measurement

/* File: verif/touch_pad_model.sv */
`timescale 1ns/10ps
module touch_pad_model (
  input wire logic i_core_clk,
  input wire logic i_ref_en,
  input wire logic [1:0] i_key_en,
  input wire logic [1:0] i_ref_half,
  input wire logic [1:0] i_k1_half,
  input wire logic [1:0] i_k2_half,
  output logic o_ref,
  output logic o_k1,
  output logic o_k2
);
  int cr;
  int c1;
  int c2;
  initial begin
    cr = 0;
    c1 = 0;
    c2 = 0;
    o_ref = 1'b0;
    o_k1 = 1'b0;
    o_k2 = 1'b0;
  end
  ////////////////////////////////////////
  // a stopped oscillator rests low, so no stray edge is left for the counters
  always @(posedge i_core_clk) begin
    cr <= (i_ref_en && cr < i_ref_half) ? cr + 1 : 0;
    o_ref <= i_ref_en ? (cr >= i_ref_half ? ~o_ref : o_ref) : 1'b0;
    c1 <= (i_key_en[0] && c1 < i_k1_half) ? c1 + 1 : 0;
    o_k1 <= i_key_en[0] ? (c1 >= i_k1_half ? ~o_k1 : o_k1) : 1'b0;
    c2 <= (i_key_en[1] && c2 < i_k2_half) ? c2 + 1 : 0;
    o_k2 <= i_key_en[1] ? (c2 >= i_k2_half ? ~o_k2 : o_k2) : 1'b0;
  end
endmodule : touch_pad_model

/* File: verif/touch_key_cf_measurement_tb.sv */
`timescale 1ns/10ps
`include "touch_key_regs.svh"
module touch_key_cf_measurement_tb
  import touch_key_pkg::*;
;
  logic clk, rst_n, wr, rd, irq, ref_osc, k1, k2, ref_en, sync, act;
  logic [3:0] addr;
  logic [7:0] wdata, rdata, rv;
  logic [1:0] key_en, rh, h1, h2;
  count16_t v, v2;
  int error_cnt = 0;
  int num_checks = 0;
  int cyc = 0;
  logic [7:0] cfg [6] = '{8'h93, 8'h91, 8'h92, 8'h33, 8'h83, 8'h31};

  touch_key_cf_measurement DUT (.i_core_clk(clk), .i_rst_n(rst_n), .i_addr(addr),
    .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_irq(irq),
    .i_ref_osc(ref_osc), .i_first_key_input(k1), .i_second_key_input(k2),
    .o_ref_osc_en(ref_en), .o_key_osc_en(key_en), .o_osc_sync(sync),
    .o_window_active(act));
  touch_pad_model pads (.i_core_clk(clk), .i_ref_en(ref_en), .i_key_en(key_en),
    .i_ref_half(rh), .i_k1_half(h1), .i_k2_half(h2), .o_ref(ref_osc), .o_k1(k1), .o_k2(k2));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  ////////////////////////////////////////
  task results;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : results

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      results();
    end
  end

  task chk(input string n, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %s exp %0h got %0h", n, e, g);
    end
  endtask : chk

  task chk_near(input string n, input int e, input logic [15:0] g, input int tol);
    num_checks++;
    if ($isunknown(g) || int'(g) < e - tol || int'(g) > e + tol) begin
      error_cnt++;
      $display("mismatch %s exp %0d got %0d", n, e, g);
    end
  endtask : chk_near

  task wrr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wrr

  task rdr(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask : rdr

  task rd16(input logic [3:0] a, output count16_t r);
    rdr(a, r[7:0]);
    rdr(a + 4'h1, r[15:8]);
  endtask : rd16
  ////////////////////////////////////////
  task meas(input logic [7:0] c, input logic [7:0] p);
    int win, per, e, f;
    win = 0;
    wrr(`TK_ADDR_CTRL, c);
    wrr(`TK_ADDR_SLOT_PRESET, p);
    wrr(`TK_ADDR_STATUS, 8'h07);
    wrr(`TK_ADDR_START, 8'h00);
    wrr(`TK_ADDR_START, 8'h01);
    @(posedge clk);
    #1;
    chk("sync", 16'h1, sync);
    chk("ref_en", c[5], ref_en);
    chk("key_en", {2{c[4]}} & c[1:0], key_en);
    while (act === 1'b1 && win < 5000) begin
      @(posedge clk);
      #1;
      win++;
    end
    per = c[7] ? 4 : 2 * (rh + 1);
    e = 32 * (256 - p) * per;
    f = (c[4] && c[0] ? e / (2 * (h1 + 1)) : 0) + (c[4] && c[1] ? e / (2 * (h2 + 1)) : 0);
    chk_near("window", e, 16'(win), per + 4);
    chk("osc_off", 16'h0, {ref_en, key_en});
    rd16(`TK_ADDR_FN_LO, v);
    chk_near("func", e / 4, v, 2);
    rd16(`TK_ADDR_CF_LO, v);
    chk_near("freq", f, v, 4);
    rdr(`TK_ADDR_STATUS, rv);
    chk("status", 16'h1, rv);
    rd16(`TK_ADDR_CF_LO, v2);
    chk("held", v, v2);
  endtask : meas
  ////////////////////////////////////////
  initial begin
    rst_n = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 4'h0;
    wdata = 8'h00;
    rh = 2'h0;
    h1 = 2'h0;
    h2 = 2'h0;
    void'($urandom(29));
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    foreach (cfg[i]) begin
      rdr(4'(i) * 4'h3, rv);
      chk("reset_val", 16'h0, rv);
    end
    wrr(`TK_ADDR_CTRL, 8'hFF);
    rdr(`TK_ADDR_CTRL, rv);
    chk("ctrl", 16'hB3, rv);
    foreach (cfg[i]) begin
      rh <= 2'($urandom % 4);
      h1 <= 2'($urandom % 4);
      h2 <= 2'($urandom % 4);
      meas(cfg[i], 8'hFC + 8'($urandom % 4));
    end
    wrr(`TK_ADDR_MASK, 8'h00);
    wrr(`TK_ADDR_STATUS, 8'h00);
    repeat (2) @(posedge clk);
    #1;
    chk("irq_masked", 16'h0, irq);
    wrr(`TK_ADDR_MASK, 8'h01);
    repeat (2) @(posedge clk);
    #1;
    chk("irq", 16'h1, irq);
    wrr(`TK_ADDR_STATUS, 8'h01);
    repeat (2) @(posedge clk);
    #1;
    chk("irq_clr", 16'h0, irq);
    wrr(`TK_ADDR_CTRL, 8'h93);
    wrr(`TK_ADDR_SLOT_PRESET, 8'hF0);
    wrr(`TK_ADDR_START, 8'h00);
    wrr(`TK_ADDR_START, 8'h01);
    repeat (20) @(posedge clk);
    #1;
    chk("abort_run", 16'h1, act);
    wrr(`TK_ADDR_START, 8'h00);
    repeat (2) @(posedge clk);
    #1;
    chk("abort", 16'h0, {act, ref_en, key_en});
    rdr(`TK_ADDR_STATUS, rv);
    chk("abort_stat", 16'h0, rv);
    rd16(`TK_ADDR_FN_LO, v);
    chk("abort_fn", 16'h0, v);
    results();
  end
endmodule : touch_key_cf_measurement_tb
